// ### verilog/sfm_monitor.sv
// fault status byte and supervision of the synchronisation inputs
//
// Notes on behaviour
// - each bit: 0 healthy, 1 fault
// - bit 7: management link lost, only when enabled
// - bit 5: keyword set and four wrong entries
// - bit 4: summer-time data incomplete
// - bit 2: quartz adjust fail, hold crystal state
// - bit 1 set by reset, then by evaluation
// - bit 1 per mode, any used protocol
// - quality counter 0..60, +1 on pass
// - a failed per-second check decrements counter
// - counter starts 0; error until above 30, again at 0
// - gps string: structure, time, visibility error
// - pps period 1000 ms within 10 ms
// - pps width change above 40 ms fails
// - pps wider than 800 ms fails
// - master/slave string: structure and time only
// - minute protocols set bit 1 directly
// - dcf pulse 100 or 200 ms, 20 ms
// - bit 0 clear at reset, per mode
// - timeouts: string 181, pps 61, dcf 25 s
// - activity restarts timeout, clears bit 0
`timescale 1ns/100ps
module sfm_monitor
    import sfm_pkg::*;
#(
    parameter int MS_CYCLES = CYC_PER_MS,
    parameter logic [QUAL_W-1:0] QUAL_REARM = 6'h00
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic clkEn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic secTick,
    input wire logic strValid,
    input wire logic strStructOk,
    input wire logic strTimeOk,
    input wire logic strVisErr,
    input wire logic ppsIn,
    input wire logic dcfIn,
    input wire logic dcfMinute,
    input wire logic dcfStructOk,
    input wire logic dcfTimeOk,
    input wire logic mgmtLinkOk,
    input wire logic keywordSet,
    input wire logic keyWrong,
    input wire logic keyRight,
    input wire logic keyUnlock,
    input wire logic dstIncomplete,
    input wire logic quartzAdjFail,
    output logic [7:0] faultByte,
    output logic crystalHold
);

    typedef struct packed {
        logic waitReq;
        logic [31:0] rdData;
        sfm_mode_t mode;
        logic strMinute;
        logic mgmtEn;
        logic [MS_W-1:0] msCnt;
        logic ppsLvl;
        logic dcfLvl;
        logic [T_W-1:0] ppsPer;
        logic [T_W-1:0] ppsWid;
        logic [T_W-1:0] ppsPrevW;
        logic ppsPrevV;
        logic ppsSeen;
        logic ppsBad;
        logic strSeen;
        logic strBad;
        logic [QUAL_W-1:0] strQ;
        logic [QUAL_W-1:0] ppsQ;
        logic strErr;
        logic ppsErr;
        logic dcfErr;
        logic [T_W-1:0] dcfWid;
        logic dcfBad;
        logic [TO_W-1:0] strTo;
        logic [TO_W-1:0] ppsTo;
        logic [TO_W-1:0] dcfTo;
        logic strDead;
        logic ppsDead;
        logic dcfDead;
        logic [2:0] wrongCnt;
        logic [7:0] fault;
        logic xtalHold;
    } sfm_state_t;

    sfm_state_t s_q;
    sfm_state_t s_d;

    logic msTick;
    logic ppsRise;
    logic ppsFall;
    logic dcfRise;
    logic dcfFall;
    logic strMinMode;
    logic strPass;
    logic [T_W-1:0] ppsWidDiff;
    logic [T_W-1:0] ppsWidNow;

    function automatic logic [QUAL_W-1:0] qualStep(input logic [QUAL_W-1:0] q, input logic pass);
        if (pass)
            qualStep = (q == QUAL_MAX) ? q : q + 6'h01;
        else
            qualStep = (q == QUAL_MIN) ? q : q - 6'h01;
    endfunction

    // hysteresis keeps the flag steady between the rearm level and 30
    function automatic logic qualErr(input logic [QUAL_W-1:0] q, input logic err);
        if (q > QUAL_ERR_TOP)
            qualErr = 1'b0;
        else if (q <= QUAL_REARM)
            qualErr = 1'b1;
        else
            qualErr = err;
    endfunction

    function automatic logic inWindow(input logic [T_W-1:0] v, input logic [T_W-1:0] c,
                                      input logic [T_W-1:0] tol);
        inWindow = (v >= c - tol) && (v <= c + tol);
    endfunction

    function automatic logic [T_W-1:0] satInc(input logic [T_W-1:0] v);
        satInc = (v == T_SAT) ? v : v + 11'h001;
    endfunction

    assign msTick = (s_q.msCnt == MS_W'(MS_CYCLES - 1));
    assign ppsRise = ppsIn & ~s_q.ppsLvl;
    assign ppsFall = ~ppsIn & s_q.ppsLvl;
    assign dcfRise = dcfIn & ~s_q.dcfLvl;
    assign dcfFall = ~dcfIn & s_q.dcfLvl;
    assign strMinMode = s_q.strMinute && (s_q.mode == MODE_MS || s_q.mode == MODE_MSPPS);
    assign strPass = s_q.strSeen & ~s_q.strBad;
    assign ppsWidNow = (msTick && s_q.ppsLvl) ? satInc(s_q.ppsWid) : s_q.ppsWid;
    assign ppsWidDiff = (ppsWidNow > s_q.ppsPrevW) ? ppsWidNow - s_q.ppsPrevW : s_q.ppsPrevW - ppsWidNow;

    always_comb
    begin
        logic strCheckBad;
        logic protoErr;
        logic chanDead;
        strCheckBad = 1'b0;
        protoErr = 1'b0;
        chanDead = 1'b0;
        s_d = s_q;

        // bus slave: one wait cycle, then one cycle with waitrequest low
        s_d.waitReq = ~((avs_read | avs_write) & s_q.waitReq);
        if (avs_read && s_q.waitReq)
        begin
            case (avs_address)
                REG_FAULT: s_d.rdData = {24'h000000, s_q.fault};
                REG_CTRL: s_d.rdData = {28'h0000000, s_q.mgmtEn, s_q.strMinute, s_q.mode};
                REG_QUAL: s_d.rdData = {18'h00000, s_q.ppsQ, 2'h0, s_q.strQ};
                default: s_d.rdData = 32'h00000000;
            endcase
        end
        if (avs_write && !s_q.waitReq && avs_address == REG_CTRL)
        begin
            s_d.mode = sfm_mode_t'(avs_writedata[CTRL_MODE_LSB +: 2]);
            s_d.strMinute = avs_writedata[CTRL_STRMIN_BIT];
            s_d.mgmtEn = avs_writedata[CTRL_MGMT_BIT];
        end

        s_d.msCnt = msTick ? '0 : s_q.msCnt + MS_W'(1);
        s_d.ppsLvl = ppsIn;
        s_d.dcfLvl = dcfIn;

        // serial string, checked per second or taken per minute
        if (secTick && !strMinMode)
        begin
            s_d.strQ = qualStep(s_q.strQ, strPass);
            s_d.strErr = qualErr(s_d.strQ, s_q.strErr);
            s_d.strSeen = 1'b0;
            s_d.strBad = 1'b0;
        end
        if (strValid)
        begin
            // visibility error only counts against the satellite receiver
            strCheckBad = ~strStructOk | ~strTimeOk | (strVisErr & (s_q.mode == MODE_GPS));
            s_d.strSeen = 1'b1;
            s_d.strBad = s_d.strBad | strCheckBad;
            if (strMinMode)
                s_d.strErr = strCheckBad;
        end

        // pps period and width, and dcf pulse width, in milliseconds
        if (msTick)
        begin
            s_d.ppsPer = satInc(s_q.ppsPer);
            if (s_q.ppsLvl)
                s_d.ppsWid = satInc(s_q.ppsWid);
            if (s_q.dcfLvl)
                s_d.dcfWid = satInc(s_q.dcfWid);
        end
        if (secTick)
        begin
            s_d.ppsQ = qualStep(s_q.ppsQ, s_q.ppsSeen & ~s_q.ppsBad);
            s_d.ppsErr = qualErr(s_d.ppsQ, s_q.ppsErr);
            s_d.ppsSeen = 1'b0;
            s_d.ppsBad = 1'b0;
        end
        if (ppsRise)
        begin
            s_d.ppsSeen = 1'b1;
            if (!inWindow(msTick ? satInc(s_q.ppsPer) : s_q.ppsPer, PPS_PERIOD_MS, PPS_PERIOD_TOL_MS))
                s_d.ppsBad = 1'b1;
            s_d.ppsPer = '0;
            s_d.ppsWid = '0;
        end
        if (ppsFall)
        begin
            if (ppsWidNow > PPS_WIDTH_MAX_MS)
                s_d.ppsBad = 1'b1;
            if (s_q.ppsPrevV && ppsWidDiff > PPS_WIDTH_DEV_MS)
                s_d.ppsBad = 1'b1;
            s_d.ppsPrevW = ppsWidNow;
            s_d.ppsPrevV = 1'b1;
        end

        // dcf pulse widths gather over the minute, verdict at minute mark
        if (dcfRise)
            s_d.dcfWid = '0;
        if (dcfFall && !inWindow(s_q.dcfWid, DCF_LOW_MS, DCF_TOL_MS)
            && !inWindow(s_q.dcfWid, DCF_HIGH_MS, DCF_TOL_MS))
            s_d.dcfBad = 1'b1;
        if (dcfMinute)
        begin
            s_d.dcfErr = ~dcfStructOk | ~dcfTimeOk | s_d.dcfBad;
            s_d.dcfBad = 1'b0;
        end

        // inactivity timeouts in seconds; activity beats the tick
        if (secTick)
        begin
            if (s_q.strTo == STR_TIMEOUT_S - 8'h01)
                s_d.strDead = 1'b1;
            else
                s_d.strTo = s_q.strTo + 8'h01;
            if (s_q.ppsTo == PPS_TIMEOUT_S - 8'h01)
                s_d.ppsDead = 1'b1;
            else
                s_d.ppsTo = s_q.ppsTo + 8'h01;
            if (s_q.dcfTo == DCF_TIMEOUT_S - 8'h01)
                s_d.dcfDead = 1'b1;
            else
                s_d.dcfTo = s_q.dcfTo + 8'h01;
        end
        if (strValid)
        begin
            s_d.strTo = '0;
            s_d.strDead = 1'b0;
        end
        if (ppsRise)
        begin
            s_d.ppsTo = '0;
            s_d.ppsDead = 1'b0;
        end
        if (dcfRise)
        begin
            s_d.dcfTo = '0;
            s_d.dcfDead = 1'b0;
        end

        // keypad lockout counter; a right keyword or unlock restarts it
        if (keyRight || keyUnlock || !keywordSet)
            s_d.wrongCnt = '0;
        else if (keyWrong && s_q.wrongCnt != KEY_LOCK_COUNT)
            s_d.wrongCnt = s_q.wrongCnt + 3'h1;

        // per-mode selection of used protocols and channels
        case (s_q.mode)
            MODE_GPS, MODE_MSPPS:
            begin
                protoErr = s_q.strErr | s_q.ppsErr;
                chanDead = s_q.strDead | s_q.ppsDead;
            end
            MODE_MS:
            begin
                protoErr = s_q.strErr;
                chanDead = s_q.strDead;
            end
            MODE_DCF:
            begin
                protoErr = s_q.dcfErr;
                chanDead = s_q.dcfDead;
            end
            default:
            begin
                protoErr = 1'b1;
                chanDead = 1'b1;
            end
        endcase

        s_d.fault = 8'h00;
        s_d.fault[FB_MGMT] = s_q.mgmtEn & ~mgmtLinkOk;
        s_d.fault[FB_KEYPAD] = keywordSet & (s_q.wrongCnt == KEY_LOCK_COUNT);
        s_d.fault[FB_DST] = dstIncomplete;
        s_d.fault[FB_QUARTZ] = quartzAdjFail;
        s_d.fault[FB_PROTO] = protoErr;
        s_d.fault[FB_CHANNEL] = chanDead;
        s_d.xtalHold = quartzAdjFail;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_q <= '0;
            s_q.waitReq <= 1'b1;
            s_q.strErr <= 1'b1;
            s_q.ppsErr <= 1'b1;
            s_q.dcfErr <= 1'b1;
            s_q.fault[FB_PROTO] <= 1'b1;
        end
        else if (clkEn)
        begin
            s_q <= s_d;
        end
    end

    assign avs_readdata = s_q.rdData;
    assign avs_waitrequest = s_q.waitReq;
    assign faultByte = s_q.fault;
    assign crystalHold = s_q.xtalHold;

    chk_unused_bits: assert property (@(posedge clk) disable iff (!nrst) !faultByte[6] && !faultByte[3])
        else $error("unassigned fault bits not zero");
    chk_mgmt_gate: assert property (@(posedge clk) disable iff (!nrst)
        (clkEn && !s_q.mgmtEn) |=> !faultByte[FB_MGMT])
        else $error("management fault while board disabled");
    chk_key_lock: assert property (@(posedge clk) disable iff (!nrst)
        (clkEn && keywordSet && s_q.wrongCnt == KEY_LOCK_COUNT) |=> faultByte[FB_KEYPAD])
        else $error("keypad lockout not flagged");
    chk_dst_flag: assert property (@(posedge clk) disable iff (!nrst)
        clkEn |=> faultByte[FB_DST] == $past(dstIncomplete))
        else $error("dst fault does not follow its cause");
    chk_xtal_hold: assert property (@(posedge clk) disable iff (!nrst) crystalHold == faultByte[FB_QUARTZ])
        else $error("crystal hold differs from quartz fault");
    chk_qual_range: assert property (@(posedge clk) disable iff (!nrst)
        s_q.strQ <= QUAL_MAX && s_q.ppsQ <= QUAL_MAX)
        else $error("quality counter out of range");
    chk_qual_down: assert property (@(posedge clk) disable iff (!nrst)
        (clkEn && secTick && !strMinMode && s_q.strBad && s_q.strQ != QUAL_MIN)
        |=> s_q.strQ == $past(s_q.strQ) - 6'h01)
        else $error("failed second did not decrement");
    chk_err_clear: assert property (@(posedge clk) disable iff (!nrst)
        (clkEn && secTick && !strMinMode && strPass && s_q.strQ == QUAL_ERR_TOP) |=> !s_q.strErr)
        else $error("error not cleared above 30");
    chk_pps_timeout: assert property (@(posedge clk) disable iff (!nrst)
        (clkEn && secTick && !ppsRise && s_q.ppsTo == PPS_TIMEOUT_S - 8'h01) |=> s_q.ppsDead)
        else $error("pps timeout did not fire");
    chk_activity_clr: assert property (@(posedge clk) disable iff (!nrst)
        (clkEn && strValid) |=> !s_q.strDead && s_q.strTo == '0)
        else $error("string activity did not restart timeout");
    chk_bus_answer: assert property (@(posedge clk) disable iff (!nrst)
        (clkEn && avs_read && avs_waitrequest) |=> !avs_waitrequest)
        else $error("read not answered after one wait cycle");

endmodule // sfm_monitor

// ### verilog/sfm_pkg.sv
// constants, types and register map of the sync source fault monitor
package sfm_pkg;
    // clock rate and the millisecond tick derived from it
    localparam int CLK_HZ = 125000000;
    localparam int MS_PER_S = 1000;
    localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
    localparam int MS_W = 20;

    // quality counter
    localparam int QUAL_W = 6;
    localparam logic [QUAL_W-1:0] QUAL_MIN = 6'h00;
    localparam logic [QUAL_W-1:0] QUAL_MAX = 6'h3C;
    localparam logic [QUAL_W-1:0] QUAL_ERR_TOP = 6'h1E;

    // pulse timing in milliseconds
    localparam int T_W = 11;
    localparam logic [T_W-1:0] T_SAT = 11'h7FF;
    localparam logic [T_W-1:0] PPS_PERIOD_MS = 11'h3E8;
    localparam logic [T_W-1:0] PPS_PERIOD_TOL_MS = 11'h00A;
    localparam logic [T_W-1:0] PPS_WIDTH_DEV_MS = 11'h028;
    localparam logic [T_W-1:0] PPS_WIDTH_MAX_MS = 11'h320;
    localparam logic [T_W-1:0] DCF_LOW_MS = 11'h064;
    localparam logic [T_W-1:0] DCF_HIGH_MS = 11'h0C8;
    localparam logic [T_W-1:0] DCF_TOL_MS = 11'h014;

    // inactivity timeouts in seconds
    localparam int TO_W = 8;
    localparam logic [TO_W-1:0] STR_TIMEOUT_S = 8'hB5;
    localparam logic [TO_W-1:0] PPS_TIMEOUT_S = 8'h3D;
    localparam logic [TO_W-1:0] DCF_TIMEOUT_S = 8'h19;

    // keypad lockout after this many wrong keywords
    localparam logic [2:0] KEY_LOCK_COUNT = 3'h4;

    // register byte offsets
    localparam logic [3:0] REG_FAULT = 4'h0;
    localparam logic [3:0] REG_CTRL = 4'h4;
    localparam logic [3:0] REG_QUAL = 4'h8;

    // control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_STRMIN_BIT = 2;
    localparam int CTRL_MGMT_BIT = 3;
    // quality register fields
    localparam int QREG_STR_LSB = 0;
    localparam int QREG_PPS_LSB = 8;

    // fault byte bit positions
    localparam int FB_CHANNEL = 0;
    localparam int FB_PROTO = 1;
    localparam int FB_QUARTZ = 2;
    localparam int FB_DST = 4;
    localparam int FB_KEYPAD = 5;
    localparam int FB_MGMT = 7;

    typedef enum logic [1:0] {MODE_GPS, MODE_MS, MODE_MSPPS, MODE_DCF} sfm_mode_t;
endpackage

// ### tb/sfm_sync_source.sv
// model of the sync source: pps, radio pulses and time strings
`timescale 1ns/100ps
module sfm_sync_source
#(
    parameter int MS_CYCLES = 4
)
(
    input wire logic clk,
    output logic ppsIn,
    output logic dcfIn,
    output logic strValid,
    output logic strStructOk,
    output logic strTimeOk,
    output logic strVisErr
);
    initial
    begin
        ppsIn = 1'h0;
        dcfIn = 1'h0;
        strValid = 1'h0;
        strStructOk = 1'h0;
        strTimeOk = 1'h0;
        strVisErr = 1'h1;
    end

    // one second of pps: high for w ms, low for the rest of p ms
    task automatic pps_sec(input int p, input int w);
        ppsIn <= 1'h1;
        repeat (w * MS_CYCLES) @(posedge clk);
        ppsIn <= 1'h0;
        repeat ((p - w) * MS_CYCLES) @(posedge clk);
    endtask

    task automatic dcf_pulse(input int w);
        dcfIn <= 1'h1;
        repeat (w * MS_CYCLES) @(posedge clk);
        dcfIn <= 1'h0;
        @(posedge clk);
    endtask

    // flags mean nothing outside strValid, so they flip there
    task automatic send_str(input logic s, input logic t, input logic v);
        strValid <= 1'h1;
        strStructOk <= s;
        strTimeOk <= t;
        strVisErr <= v;
        @(posedge clk);
        strValid <= 1'h0;
        strStructOk <= ~s;
        strTimeOk <= ~t;
        strVisErr <= ~v;
        @(posedge clk);
    endtask
endmodule // sfm_sync_source

// ### tb/testbench.sv
// self-checking bench for the sync source fault monitor
`timescale 1ns/100ps
module testbench;
    import sfm_pkg::*;
    localparam int MSC = 4;
    logic clk, nrst, secTick, keywordSet, keyWrong, keyRight, keyUnlock, dcfMinute, dcfStructOk, dcfTimeOk;
    logic avs_read, avs_write, mgmtLinkOk, dstIncomplete, quartzAdjFail, avs_waitrequest, crystalHold;
    logic ppsIn, dcfIn, strValid, strStructOk, strTimeOk, strVisErr, ok, err;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd, r;
    logic [31:0] seed = 32'h3F27;
    logic [7:0] faultByte;
    logic [5:0] q;
    int fails = 0;
    int checked = 0;
    int lim;
    int pp[10] = '{1000, 1000, 1000, 1010, 990, 1000, 1011, 1000, 989, 1000};
    int pw[10] = '{760, 780, 800, 800, 801, 790, 750, 750, 709, 709};

    sfm_monitor #(.MS_CYCLES(MSC)) i_sfm_monitor (.clk(clk), .nrst(nrst), .clkEn(1'h1),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .secTick(secTick), .strValid(strValid),
        .strStructOk(strStructOk), .strTimeOk(strTimeOk), .strVisErr(strVisErr), .ppsIn(ppsIn), .dcfIn(dcfIn),
        .dcfMinute(dcfMinute), .dcfStructOk(dcfStructOk), .dcfTimeOk(dcfTimeOk), .mgmtLinkOk(mgmtLinkOk),
        .keywordSet(keywordSet),
        .keyWrong(keyWrong), .keyRight(keyRight), .keyUnlock(keyUnlock), .dstIncomplete(dstIncomplete),
        .quartzAdjFail(quartzAdjFail), .faultByte(faultByte), .crystalHold(crystalHold));
    sfm_sync_source #(.MS_CYCLES(MSC)) i_sfm_sync_source (.clk(clk), .ppsIn(ppsIn), .dcfIn(dcfIn),
        .strValid(strValid), .strStructOk(strStructOk), .strTimeOk(strTimeOk), .strVisErr(strVisErr));

    initial
    begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    function automatic logic [31:0] xrand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [5:0] qstep(input logic [5:0] qi, input logic pass);
        if (pass)
            return (qi == 6'h3C) ? qi : qi + 6'h01;
        return (qi == 6'h00) ? qi : qi - 6'h01;
    endfunction

    function automatic logic pps_ok(input int per, input int w, input int pw0, input bit first);
        return !first && per >= 990 && per <= 1010 && w - pw0 <= 40 && pw0 - w <= 40 && w <= 800;
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'h0 && n < 100);
        rd = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        if (n >= 100)
            check("bus answer", 32'h1, 32'h0);
        @(posedge clk);
    endtask

    task automatic do_reset();
        nrst <= 1'h0;
        repeat (20) @(posedge clk);
        nrst <= 1'h1;
        @(posedge clk);
    endtask

    task automatic settle();
        repeat (4) @(posedge clk);
    endtask

    task automatic tick();
        secTick <= 1'h1;
        @(posedge clk);
        secTick <= 1'h0;
        @(posedge clk);
    endtask

    initial
    begin
        repeat (70000) @(posedge clk);
        fails++;
        end_sim();
    end

    initial
    begin
        {nrst, secTick, keywordSet, keyWrong, keyRight, keyUnlock, avs_read, avs_write} = 8'h00;
        {dcfMinute, dcfStructOk, dcfTimeOk} = 3'h0;
        {dstIncomplete, quartzAdjFail, mgmtLinkOk} = 3'h1;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        @(posedge clk);
        do_reset();
        check("fault after reset", 32'(faultByte), 32'h02);
        check("hold after reset", 32'(crystalHold), 32'h0);
        bus(1'h1, REG_FAULT, 32'hFF);
        bus(1'h1, 4'hC, 32'hFF);
        for (int a = 0; a < 4; a++)
        begin
            bus(1'h0, 4'(a * 4), 32'h0);
            check("register reset", rd, (a == 0) ? 32'h02 : 32'h0);
        end
        for (int i = 0; i < 12; i++)
        begin
            r = xrand();
            quartzAdjFail <= r[0];
            dstIncomplete <= r[1];
            mgmtLinkOk <= r[2];
            bus(1'h1, REG_CTRL, {28'h0, r[3], 3'h1});
            settle();
            check("static bits", 32'(faultByte & 8'hFC), 32'({!r[2] & r[3], 2'h0, r[1], 1'h0, r[0], 2'h0}));
            check("crystal hold", 32'(crystalHold), 32'(r[0]));
        end
        {dstIncomplete, quartzAdjFail, mgmtLinkOk} <= 3'h1;
        keywordSet <= 1'h1;
        for (int m = 0; m < 3; m++)
        begin
            for (int k = 0; k < 4; k++)
            begin
                settle();
                check("keypad early", 32'(faultByte[5]), 32'h0);
                keyWrong <= 1'h1;
                @(posedge clk);
                keyWrong <= 1'h0;
            end
            settle();
            check("keypad locked", 32'(faultByte[5]), 32'h1);
            keyRight <= (m == 0);
            keyUnlock <= (m == 1);
            keywordSet <= (m != 2);
            @(posedge clk);
            {keyRight, keyUnlock, keywordSet} <= 3'h1;
            settle();
            check("keypad cleared", 32'(faultByte[5]), 32'h0);
        end
        // counter walk: climb to the top, sink with one pass in four, then wander
        do_reset();
        bus(1'h1, REG_CTRL, 32'h1);
        q = 6'h00;
        err = 1'h1;
        for (int i = 0; i < 176; i++)
        begin
            r = xrand();
            ok = (i < 64) ? 1'h1 : (i < 128) ? (r[3:2] == 2'h0) : r[4];
            if (ok || r[5])
                i_sfm_sync_source.send_str(ok, ok | r[0], r[1]);
            tick();
            q = qstep(q, ok);
            err = (q > 6'h1E) ? 1'h0 : (q == 6'h00) ? 1'h1 : err;
            settle();
            bus(1'h0, REG_QUAL, 32'h0);
            check("string quality", 32'(rd[5:0]), 32'(q));
            check("plausibility", 32'(faultByte[1]), 32'(err));
        end
        for (int t = 0; t < 3; t++)
        begin
            do_reset();
            bus(1'h1, REG_CTRL, 32'(t + 1));
            lim = (t == 0) ? 181 : (t == 1) ? 61 : 25;
            for (int s = 1; s <= lim; s++)
            begin
                if (t == 1)
                    i_sfm_sync_source.send_str(1'h1, 1'h1, 1'h0);
                tick();
                settle();
                check("channel timeout", 32'(faultByte[0]), 32'(s >= lim));
            end
            if (t == 0)
                i_sfm_sync_source.send_str(1'h1, 1'h1, 1'h0);
            else if (t == 1)
                i_sfm_sync_source.pps_sec(2, 1);
            else
                i_sfm_sync_source.dcf_pulse(100);
            settle();
            check("channel activity", 32'(faultByte[0]), 32'h0);
        end
        do_reset();
        bus(1'h1, REG_CTRL, 32'h5);
        for (int i = 0; i < 4; i++)
        begin
            r = xrand();
            i_sfm_sync_source.send_str(i[0], 1'h1, r[1]);
            tick();
            settle();
            check("minute plausibility", 32'(faultByte[1]), 32'(!i[0]));
        end
        // radio minute verdict: widths far from the window edges
        do_reset();
        bus(1'h1, REG_CTRL, 32'h3);
        for (int k = 0; k < 6; k++)
        begin
            r = xrand();
            lim = (k < 2) ? 100 * (k + 1) : (r[0] ? 150 : (r[1] ? 260 : 200));
            ok = r[2] | (k == 0);
            i_sfm_sync_source.dcf_pulse(lim);
            dcfStructOk <= ok;
            dcfTimeOk <= 1'h1;
            dcfMinute <= 1'h1;
            @(posedge clk);
            dcfMinute <= 1'h0;
            settle();
            check("radio plausibility", 32'(faultByte[1]), 32'(!ok || lim == 150 || lim == 260));
        end
        do_reset();
        bus(1'h1, REG_CTRL, 32'h2);
        q = 6'h00;
        for (int k = 0; k < 10; k++)
        begin
            fork
                i_sfm_sync_source.pps_sec(pp[k], pw[k]);
                begin
                    repeat (pw[k] * MSC + 20) @(posedge clk);
                    tick();
                    bus(1'h0, REG_QUAL, 32'h0);
                    q = qstep(q, pps_ok(k == 0 ? 1000 : pp[k - 1], pw[k], k == 0 ? pw[k] : pw[k - 1], k == 0));
                    check("pps quality", 32'(rd[13:8]), 32'(q));
                end
            join
        end
        end_sim();
    end
endmodule // testbench
